//--- verilog/ict_pkg.sv
// Package for the instruction cycle timing sequencer: classes, operand kinds, counts.
// Assumes a single core clock in which one clock edge is one state time.
package ict_pkg;

  // Instruction classes the sequencer times
  typedef enum logic [3:0] {
    ICT_TABLE_INDIRECT_JUMP = 4'h0,
    ICT_POWER_SAVING_ENTRY = 4'h1,
    ICT_EXTENDED_FAR_CALL = 4'h2,
    ICT_LONG_CALL = 4'h3,
    ICT_SHORT_CALL = 4'h4,
    ICT_SUBROUTINE_EXIT = 4'h5,
    ICT_INTERRUPT_HANDLER_EXIT = 4'h6,
    ICT_SOFTWARE_TRAP = 4'h7,
    ICT_PLAIN_BLOCK_MOVE = 4'h8,
    ICT_INTERRUPTIBLE_BLOCK_MOVE = 4'h9,
    ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE = 4'ha
  } ict_class_t;

  // Operand placement: register/register, memory/register, memory/memory
  typedef enum logic [1:0] {
    ICT_OPS_REG_REG = 2'h0,
    ICT_OPS_MEM_REG = 2'h1,
    ICT_OPS_MEM_MEM = 2'h2
  } ict_ops_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ICT_IDLE = 3'b001,
    ICT_RUN = 3'b010,
    ICT_MOVE = 3'b100
  } ict_state_t;

  localparam int ICT_CW = 8;
  localparam logic [7:0] ICT_TABLE_INDIRECT_JUMP_REG = 8'h06;
  localparam logic [7:0] ICT_TABLE_INDIRECT_JUMP_MEM = 8'h08;
  localparam logic [7:0] ICT_PWR_ENTRY = 8'h03;
  localparam logic [7:0] ICT_EFCALL_REG_1M = 8'h02;
  localparam logic [7:0] ICT_EFCALL_MEM_1M = 8'h04;
  localparam logic [7:0] ICT_TRAP_REG_1M = 8'h04;
  localparam logic [7:0] ICT_TRAP_MEM_1M = 8'h06;
  localparam logic [7:0] ICT_TRAP_64K = 8'h03;
  localparam logic [7:0] ICT_EXIT_REG_1M = 8'h02;
  localparam logic [7:0] ICT_EXIT_REG_64K = 8'h01;
  localparam logic [7:0] ICT_EXIT_MEM_1M = 8'h06;
  localparam logic [7:0] ICT_EXIT_MEM_64K = 8'h03;
  localparam logic [7:0] ICT_CALL_REG_1M = 8'h02;
  localparam logic [7:0] ICT_CALL_MEM_1M = 8'h04;
  localparam logic [7:0] ICT_CALL_64K = 8'h01;
  localparam logic [7:0] ICT_PLAIN_BLOCK_MOVE_BASE = 8'h05;
  localparam logic [7:0] ICT_EBMOV_BASE = 8'h09;
  localparam logic [7:0] ICT_WORD_RR = 8'h01;
  localparam logic [7:0] ICT_WORD_MR = 8'h03;
  localparam logic [7:0] ICT_WORD_MM = 8'h05;
  localparam logic [7:0] ICT_INTERRUPTIBLE_BLOCK_MOVE_INT = 8'h06;
  localparam logic [7:0] ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE_INT = 8'h0a;
  localparam logic [7:0] ICT_CNT_RESET = 8'h00;
  localparam logic [15:0] ICT_WORDS_RESET = 16'h0000;

endpackage

//--- verilog/ict_sequencer.sv
// Instruction cycle timing sequencer: holds busy for the state-time count of each class.
// Assumes the decoder gives one start pulse with class, operands and mode on the same
// clock; stack location and addressing mode come from core logic on this clock.
// Contract
// - Table indirect jump takes 8 state times with both operands in memory, 6 otherwise.
// - Power saving entry takes 3 state times whatever the key.
// - Extended far call with register stack takes 2 state times in 1-Mbyte mode.
// - Extended far call with memory stack takes 4 state times in 1-Mbyte mode.
// - Software trap with register stack takes 4 in 1-Mbyte mode and 3 in 64-Kbyte mode.
// - Software trap with memory stack takes 6 in 1-Mbyte mode and 3 in 64-Kbyte mode.
// - Subroutine and handler exits, register stack, take 2 (1-Mbyte) or 1 (64-Kbyte).
// - Subroutine and handler exits, memory stack, take 6 (1-Mbyte) or 3 (64-Kbyte).
// - Long call takes 2/1 with register stack and 4/1 with memory stack, 1-Mbyte/64-Kbyte.
// - Short call takes 2/1 with register stack and 4/1 with memory stack, 1-Mbyte/64-Kbyte.
// - Extended interruptible move costs 9 plus 1, 3 or 5 per word plus 10 per interrupt.
// - Plain block move costs 5 plus 1, 3 or 5 per word.
// - Interruptible block move costs 5 plus 1, 3 or 5 per word plus 6 per interrupt.
`timescale 1ns/1ps
module ict_sequencer
  import ict_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Instruction start
  input wire logic start_in,
  input wire ict_pkg::ict_class_t class_in,
  input wire ict_pkg::ict_ops_t ops_in,
  input wire logic [15:0] words_in,
  // Configuration
  input wire logic mode_1mbyte_in,
  input wire logic stack_in_regs_in,
  // Interrupt request during moves
  input wire logic irq_in,
  // Status
  output logic busy_out,
  output logic done_out,
  output logic irq_taken_out,
  output logic [7:0] count_out
);
  import ict_pkg::*;

  ict_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [15:0] words_r, words_nxt;
  logic [7:0] per_word_r, per_word_nxt;
  logic [7:0] int_cost_r, int_cost_nxt;
  logic intr_ok_r, intr_ok_nxt;
  logic done_r, done_nxt;
  logic taken_r, taken_nxt;
  logic [7:0] fixed_cost;

  // Per-word cost by operand placement
  function automatic logic [7:0] word_cost(input ict_ops_t ops);
    case (ops)
      ICT_OPS_REG_REG: word_cost = ICT_WORD_RR;
      ICT_OPS_MEM_REG: word_cost = ICT_WORD_MR;
      default: word_cost = ICT_WORD_MM;
    endcase
  endfunction

  // Pick the column: stack location then addressing mode
  function automatic logic [7:0] col(input logic m1, input logic regs,
      input logic [7:0] r1, input logic [7:0] r64, input logic [7:0] s1,
      input logic [7:0] s64);
    if (regs)
      col = m1 ? r1 : r64;
    else
      col = m1 ? s1 : s64;
  endfunction

  // Fixed cost of each class, the base cost for block moves
  always_comb
  begin
    fixed_cost = ICT_PWR_ENTRY;
    case (class_in)
      ICT_TABLE_INDIRECT_JUMP: fixed_cost = (ops_in == ICT_OPS_MEM_MEM) ?
          ICT_TABLE_INDIRECT_JUMP_MEM : ICT_TABLE_INDIRECT_JUMP_REG;
      ICT_POWER_SAVING_ENTRY: fixed_cost = ICT_PWR_ENTRY;
      ICT_EXTENDED_FAR_CALL: fixed_cost = stack_in_regs_in ?
          ICT_EFCALL_REG_1M : ICT_EFCALL_MEM_1M;
      ICT_SOFTWARE_TRAP: fixed_cost = col(mode_1mbyte_in, stack_in_regs_in,
          ICT_TRAP_REG_1M, ICT_TRAP_64K, ICT_TRAP_MEM_1M, ICT_TRAP_64K);
      ICT_SUBROUTINE_EXIT, ICT_INTERRUPT_HANDLER_EXIT: fixed_cost = col(mode_1mbyte_in,
          stack_in_regs_in, ICT_EXIT_REG_1M, ICT_EXIT_REG_64K, ICT_EXIT_MEM_1M,
          ICT_EXIT_MEM_64K);
      ICT_LONG_CALL, ICT_SHORT_CALL: fixed_cost = col(mode_1mbyte_in, stack_in_regs_in,
          ICT_CALL_REG_1M, ICT_CALL_64K, ICT_CALL_MEM_1M, ICT_CALL_64K);
      ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE: fixed_cost = ICT_EBMOV_BASE;
      default: fixed_cost = ICT_PLAIN_BLOCK_MOVE_BASE;
    endcase
  end

  // Next state: fixed phase counts down, move phase charges per word and per interrupt
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    words_nxt = words_r;
    per_word_nxt = per_word_r;
    int_cost_nxt = int_cost_r;
    intr_ok_nxt = intr_ok_r;
    done_nxt = 1'b0;
    taken_nxt = 1'b0;
    case (state_r)
      ICT_IDLE:
      begin
        if (start_in)
        begin
          state_nxt = ICT_RUN;
          cnt_nxt = fixed_cost;
          per_word_nxt = word_cost(ops_in);
          words_nxt = (class_in >= ICT_PLAIN_BLOCK_MOVE) ? words_in : ICT_WORDS_RESET;
          intr_ok_nxt = (class_in == ICT_INTERRUPTIBLE_BLOCK_MOVE) ||
              (class_in == ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE);
          int_cost_nxt = (class_in == ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE) ?
              ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE_INT : ICT_INTERRUPTIBLE_BLOCK_MOVE_INT;
        end
      end
      ICT_RUN, ICT_MOVE:
      begin
        if (cnt_r > 8'h01)
          cnt_nxt = cnt_r - 8'h01;
        else if (words_r != ICT_WORDS_RESET && intr_ok_r && irq_in)
        begin
          cnt_nxt = int_cost_r;
          taken_nxt = 1'b1;
          state_nxt = ICT_MOVE;
        end
        else if (words_r != ICT_WORDS_RESET)
        begin
          cnt_nxt = per_word_r;
          words_nxt = words_r - 16'h0001;
          state_nxt = ICT_MOVE;
        end
        else
        begin
          cnt_nxt = ICT_CNT_RESET;
          done_nxt = 1'b1;
          state_nxt = ICT_IDLE;
        end
      end
      default: state_nxt = ICT_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_r <= ICT_IDLE;
      cnt_r <= ICT_CNT_RESET;
      words_r <= ICT_WORDS_RESET;
      per_word_r <= ICT_CNT_RESET;
      int_cost_r <= ICT_CNT_RESET;
      intr_ok_r <= 1'b0;
      done_r <= 1'b0;
      taken_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      words_r <= words_nxt;
      per_word_r <= per_word_nxt;
      int_cost_r <= int_cost_nxt;
      intr_ok_r <= intr_ok_nxt;
      done_r <= done_nxt;
      taken_r <= taken_nxt;
    end
  end

  // Outputs
  assign busy_out = (state_r != ICT_IDLE);
  assign done_out = done_r;
  assign irq_taken_out = taken_r;
  assign count_out = cnt_r;

  // Assertions
  a_table_indirect_jump_mem_time: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_TABLE_INDIRECT_JUMP &&
      ops_in == ICT_OPS_MEM_MEM) |=> busy_out [*8] ##1 done_out)
    else $error("table jump memory timing wrong");
  a_table_indirect_jump_reg_time: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_TABLE_INDIRECT_JUMP &&
      ops_in != ICT_OPS_MEM_MEM) |=> busy_out [*6] ##1 done_out)
    else $error("table jump register timing wrong");
  a_power_entry_time: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_POWER_SAVING_ENTRY)
      |=> ##3 done_out)
    else $error("power entry timing wrong");
  a_far_call_reg: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_EXTENDED_FAR_CALL &&
      stack_in_regs_in) |=> ##2 done_out)
    else $error("far call register stack timing wrong");
  a_far_call_mem: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_EXTENDED_FAR_CALL &&
      !stack_in_regs_in) |=> !done_out [*4] ##1 done_out)
    else $error("far call memory stack timing wrong");
  a_trap_reg_1m: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_SOFTWARE_TRAP &&
      stack_in_regs_in && mode_1mbyte_in) |=> ##4 done_out)
    else $error("trap register stack timing wrong");
  a_trap_mem_1m: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_SOFTWARE_TRAP &&
      !stack_in_regs_in && mode_1mbyte_in) |=> ##6 done_out)
    else $error("trap memory stack timing wrong");
  a_exit_reg_64k: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_SUBROUTINE_EXIT &&
      stack_in_regs_in && !mode_1mbyte_in) |=> ##1 done_out)
    else $error("exit register 64K timing wrong");
  a_exit_mem_1m: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_INTERRUPT_HANDLER_EXIT &&
      !stack_in_regs_in && mode_1mbyte_in) |=> ##6 done_out)
    else $error("exit memory 1M timing wrong");
  a_long_call_mem: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_LONG_CALL &&
      !stack_in_regs_in && mode_1mbyte_in) |=> ##4 done_out)
    else $error("long call timing wrong");
  a_short_call_64k: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_SHORT_CALL &&
      !mode_1mbyte_in) |=> ##1 done_out)
    else $error("short call timing wrong");
  a_plain_move_one: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (state_r == ICT_IDLE && start_in && class_in == ICT_PLAIN_BLOCK_MOVE &&
      words_in == 16'h0001 && ops_in == ICT_OPS_MEM_MEM) |=> ##10 done_out)
    else $error("plain move timing wrong");
  a_irq_charge: assert property (@(posedge clock_in) disable iff (!rstn_in)
      irq_taken_out |-> (count_out == ICT_INTERRUPTIBLE_BLOCK_MOVE_INT || count_out == ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE_INT)
      && busy_out)
    else $error("interrupt overhead not charged");
endmodule

//--- tb/testbench.sv
// Self-checking bench for the instruction cycle timing sequencer.
// Assumes ict_pkg and ict_sequencer are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
module testbench;
  import ict_pkg::*;
  logic clock_in, rstn_in, start_in, mode_1mbyte_in, stack_in_regs_in, irq_in;
  ict_class_t class_in;
  ict_ops_t ops_in;
  logic [15:0] words_in;
  logic busy_out, done_out, irq_taken_out;
  logic [7:0] count_out;
  int fail_count, check_count;

  ict_sequencer ict_sequencer_i (
    .clock_in(clock_in), .rstn_in(rstn_in), .start_in(start_in),
    .class_in(class_in), .ops_in(ops_in), .words_in(words_in),
    .mode_1mbyte_in(mode_1mbyte_in), .stack_in_regs_in(stack_in_regs_in),
    .irq_in(irq_in), .busy_out(busy_out), .done_out(done_out),
    .irq_taken_out(irq_taken_out), .count_out(count_out));

  // Clock, 25 ns period
  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Start one instruction, count busy cycles and interrupt charges, judge the total
  task automatic run_op(input ict_class_t c, input ict_ops_t o, input logic [15:0] w,
    input logic m, input logic s, input int q, input int base, input int ovh, input int first);
    int n;
    int tk;
    logic [7:0] c0;
    class_in = c;
    ops_in = o;
    words_in = w;
    mode_1mbyte_in = m;
    stack_in_regs_in = s;
    irq_in = (q != 0);
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    n = 0;
    tk = 0;
    c0 = count_out;
    while (busy_out === 1'b1 && n < 2000)
    begin
      n++;
      if (irq_taken_out === 1'b1)
      begin
        tk++;
        // Drop the request once the wanted number of interrupts has been charged
        if (tk >= q) irq_in = 1'b0;
      end
      @(negedge clock_in);
    end
    irq_in = 1'b0;
    chk(32'(c0), 32'(first));
    chk(32'(n), 32'(base + tk * ovh));
    chk(32'(done_out), 32'h1);
    // Only interruptible moves charge, once per interrupt requested
    if (ovh > 0) chk(32'(tk), 32'(q));
    else chk(32'(tk), 32'h0);
  endtask

  // Table jump over the three operand placements
  task automatic t_jump;
    run_op(ICT_TABLE_INDIRECT_JUMP, ICT_OPS_REG_REG, 16'h0000, 1, 1, 0, 6, 0, 6);
    run_op(ICT_TABLE_INDIRECT_JUMP, ICT_OPS_MEM_REG, 16'h0000, 0, 0, 0, 6, 0, 6);
    run_op(ICT_TABLE_INDIRECT_JUMP, ICT_OPS_MEM_MEM, 16'h0000, 1, 0, 0, 8, 0, 8);
  endtask

  // Power saving entry in both columns, interrupt pending too
  task automatic t_power;
    run_op(ICT_POWER_SAVING_ENTRY, ICT_OPS_REG_REG, 16'h0000, 1, 0, 1, 3, 0, 3);
    run_op(ICT_POWER_SAVING_ENTRY, ICT_OPS_REG_REG, 16'h0000, 0, 1, 0, 3, 0, 3);
  endtask

  // Extended far call with register and memory stack
  task automatic t_far;
    run_op(ICT_EXTENDED_FAR_CALL, ICT_OPS_REG_REG, 16'h0000, 1, 1, 0, 2, 0, 2);
    run_op(ICT_EXTENDED_FAR_CALL, ICT_OPS_REG_REG, 16'h0000, 1, 0, 0, 4, 0, 4);
  endtask

  // Trap, exits and calls in every mode and stack combination
  task automatic t_stack;
    int tr;
    int ex;
    int ca;
    ict_class_t hx;
    hx = ICT_INTERRUPT_HANDLER_EXIT;
    for (int k = 0; k < 4; k++)
    begin
      tr = k[1] ? (k[0] ? 4 : 6) : 3;
      ex = k[1] ? (k[0] ? 2 : 6) : (k[0] ? 1 : 3);
      ca = k[1] ? (k[0] ? 2 : 4) : 1;
      run_op(ICT_SOFTWARE_TRAP, ICT_OPS_REG_REG, 16'h0, k[1], k[0], 0, tr, 0, tr);
      run_op(ICT_SUBROUTINE_EXIT, ICT_OPS_REG_REG, 16'h0, k[1], k[0], 0, ex, 0, ex);
      run_op(hx, ICT_OPS_MEM_MEM, 16'h0, k[1], k[0], 0, ex, 0, ex);
      run_op(ICT_LONG_CALL, ICT_OPS_REG_REG, 16'h0, k[1], k[0], 0, ca, 0, ca);
      run_op(ICT_SHORT_CALL, ICT_OPS_REG_REG, 16'h0, k[1], k[0], 0, ca, 0, ca);
    end
  endtask

  // Block moves per operand placement, interrupt pending until the wanted count is charged
  task automatic t_moves;
    int per;
    ict_ops_t op;
    ict_class_t im;
    ict_class_t em;
    im = ICT_INTERRUPTIBLE_BLOCK_MOVE;
    em = ICT_EXTENDED_INTERRUPTIBLE_BLOCK_MOVE;
    for (int o = 0; o < 3; o++)
    begin
      per = 1 + 2 * o;
      op = ict_ops_t'(o[1:0]);
      run_op(ICT_PLAIN_BLOCK_MOVE, op, 16'h0003, 1, 1, 1, 5 + 3 * per, 0, 5);
      run_op(im, op, 16'h0003, 1, 1, 2, 5 + 3 * per, 6, 5);
      run_op(em, op, 16'h0003, 0, 0, 1, 9 + 3 * per, 10, 9);
      run_op(em, op, 16'h0001, 1, 0, 0, 9 + per, 10, 9);
    end
  endtask

  // Counts and verdict
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the tests need
  initial
  begin
    #(25 * 20000);
    fail_count++;
    summarize();
  end

  // Main sequence
  initial
  begin
    fail_count = 0;
    check_count = 0;
    rstn_in = 1'b0;
    start_in = 1'b0;
    irq_in = 1'b0;
    mode_1mbyte_in = 1'b1;
    stack_in_regs_in = 1'b1;
    class_in = ICT_TABLE_INDIRECT_JUMP;
    ops_in = ICT_OPS_REG_REG;
    words_in = 16'h0000;
    repeat (6) @(negedge clock_in);
    chk(32'({busy_out, done_out, irq_taken_out, count_out}), 32'h0);
    rstn_in = 1'b1;
    t_jump();
    t_power();
    t_far();
    t_stack();
    t_moves();
    summarize();
  end
endmodule
